/* logic/ppm_packet_crc32_fcs.sv */
// frame check generation and receive acceptance for 4-slot pulse-position packets
// Functional notes
// RULE1: check is 32-bit cyclic value of payload
// RULE2: compute over raw bits before symbol encoding
// RULE3: standard 32-bit polynomial taps
// RULE4: check leaves as four ordinary data bytes
// RULE5: payload bytes enter least significant bit first
// RULE6: preset register to ones; clear forces preset
// RULE7: zero feedback while check shifts out
// RULE8: feedback is top bit xor data
// RULE9: select low passes data, high sends inverted top
// RULE10: send inverse of register contents
// RULE11: corruption input suppresses inversion
// RULE12: async low reset presets register to ones
// RULE13: accept only valid flags, symbols, check
// RULE14: preamble not needed for acceptance
// RULE15: two dark symbols abort the packet
// RULE16: illegal non-stop symbol after start aborts
// RULE17: back-to-back packets each complete
// RULE18: one lit chip per bit pair
// RULE19: decode symbols until stop flag recognised
// RULE20: exactly sixteen preamble groups
// RULE21: receiver recomputes check, mismatch rejects
// RULE22: check select high exactly 32 clocks
`timescale 1ns/1ns
`include "ppm_fcs_consts.svh"
module ppm_packet_crc32_fcs
   import ppm_fcs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // transmit side, one payload bit per clock
   input  wire logic        txClear,
   input  wire logic        txStart,
   input  wire logic        txGroupDone,
   input  wire logic        txBitValid,
   input  wire logic        txBitIn,
   input  wire logic        txLastBit,
   input  wire logic        txBadFcs,
   output logic             txSendPreamble,
   output logic             txPayloadReady,
   output logic             txBitOut,
   output logic             txBitOutValid,
   output logic             txCrcPhase,
   // receive side, one symbol per valid
   input  wire logic        rxOpenFlag,
   input  wire logic        rxCloseFlag,
   input  wire logic        rxSymbolValid,
   input  wire logic [3:0]  rxSymbol,
   input  wire logic        rxStopChip,
   output logic      [1:0]  rxPair,
   output logic             rxPairValid,
   output logic             rxInFrame,
   output logic             rxAccept,
   output logic             rxAbort,
   output logic             rxCrcError
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   txState_t    txState_ff;
   rxState_t    rxState_ff;
   logic [4:0]  groupCnt_ff;
   logic [5:0]  checkCnt_ff;
   logic [31:0] txCrc;
   logic [31:0] rxCrc;
   logic [31:0] rxDly_ff;
   logic [4:0]  rxSymCnt_ff;
   logic [1:0]  rxSymMod_ff;
   logic [31:0] ctrl_ff;
   logic [15:0] okCnt_ff;
   logic [15:0] badCnt_ff;
   logic        prdyq_ff;
   logic [31:0] prdata_ff;
   logic        pslverr_ff;
   logic        badFcs;
   logic        txBitOut_ff;
   logic        txBitOutValid_ff;
   logic        txCrcPhase_ff;
   logic [1:0]  rxPair_ff;
   logic        rxPairValid_ff;
   logic        rxAccept_ff;
   logic        rxAbort_ff;
   logic        rxCrcError_ff;
   logic        rxInFrame_ff;
   logic        txCrcClr;
   logic        txCrcEn;
   logic        rxActive;
   logic        rxData;
   logic        rxFull;
   logic        rxLenOk;
   logic        rxMatch;
   logic        apbWr;
   logic        apbRd;
   logic [1:0]  rxSymPair;

   assign badFcs   = txBadFcs | ctrl_ff[`CTRL_BADFCS_BIT];
   assign apbWr    = psel & penable & prdyq_ff & pwrite;
   assign apbRd    = psel & ~penable & ~pwrite;

   // ---------------------------------------------------------------
   // transmit sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txState_ff  <= TX_IDLE;
         groupCnt_ff <= 5'h00;
         checkCnt_ff <= 6'h00;
      end else begin
         unique case (txState_ff)
            TX_IDLE: begin
               groupCnt_ff <= 5'h00;
               if (txStart) begin
                  txState_ff <= TX_PREAMBLE;
               end
            end
            TX_PREAMBLE: begin
               if (groupCnt_ff == `PREAMBLE_GROUPS) begin
                  txState_ff <= TX_PAYLOAD;                              // [RULE20]
               end else if (txGroupDone) begin
                  groupCnt_ff <= groupCnt_ff + 5'h01;
               end
            end
            TX_PAYLOAD: begin
               checkCnt_ff <= 6'h00;
               if (txBitValid && txLastBit) begin
                  txState_ff <= TX_CHECK;
               end
            end
            TX_CHECK: begin
               checkCnt_ff <= checkCnt_ff + 6'h01;
               if (checkCnt_ff == `FCS_CHECK_LAST) begin
                  txState_ff <= TX_IDLE;                                 // [RULE22]
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // transmit check register and output mux
   // ---------------------------------------------------------------
   assign txCrcClr = txClear | ctrl_ff[`CTRL_CLEAR_BIT] |
                     (txState_ff == TX_IDLE && txStart);                 // [RULE6]
   assign txCrcEn  = (txState_ff == TX_PAYLOAD && txBitValid) ||
                     (txState_ff == TX_CHECK);                           // [RULE1] [RULE2]

   fcs_crc32_shift #(.BITS(1)) txFcs (
      .clk       (clk),
      .rstn      (rstn),
      .clr       (txCrcClr),
      .en        (txCrcEn),
      .shiftOnly (txState_ff == TX_CHECK),                               // [RULE7]
      .din       (txBitIn),                                              // [RULE5]
      .crc_ff    (txCrc)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txBitOut_ff      <= 1'b0;
         txBitOutValid_ff <= 1'b0;
         txCrcPhase_ff    <= 1'b0;
         txSendPreamble   <= 1'b0;
         txPayloadReady   <= 1'b0;
      end else begin
         txCrcPhase_ff    <= (txState_ff == TX_CHECK);                   // [RULE22]
         txBitOutValid_ff <= txCrcEn;
         txSendPreamble   <= (txState_ff == TX_IDLE && txStart) ||
                             (txState_ff == TX_PREAMBLE &&
                              groupCnt_ff != `PREAMBLE_GROUPS);          // [RULE20]
         txPayloadReady   <= (txState_ff == TX_PAYLOAD && !(txBitValid && txLastBit)) ||
                             (txState_ff == TX_PREAMBLE &&
                              groupCnt_ff == `PREAMBLE_GROUPS);
         if (txState_ff == TX_CHECK) begin
            txBitOut_ff <= ~txCrc[31] ^ badFcs; // [RULE9] [RULE10] [RULE11] [RULE4]
         end else begin
            txBitOut_ff <= txBitIn;                                      // [RULE9]
         end
      end
   end

   // ---------------------------------------------------------------
   // receive framing
   // ---------------------------------------------------------------
   assign rxActive = (rxState_ff != RX_HUNT);
   assign rxData   = rxActive && rxSymbolValid && symLegal(rxSymbol) && !rxCloseFlag;
   assign rxFull   = (rxSymCnt_ff == `FCS_FILL_SYMS);
   assign rxLenOk  = rxFull && (rxSymMod_ff == 2'h0);
   assign rxMatch  = (rxDly_ff == ~rxCrc);                               // [RULE21]
   assign rxSymPair = symPair(rxSymbol);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxState_ff     <= RX_HUNT;
         rxAccept_ff    <= 1'b0;
         rxAbort_ff     <= 1'b0;
         rxCrcError_ff  <= 1'b0;
         rxInFrame_ff   <= 1'b0;
      end else begin
         rxAccept_ff    <= 1'b0;
         rxAbort_ff     <= 1'b0;
         rxCrcError_ff  <= 1'b0;
         if (rxOpenFlag) begin
            rxAbort_ff <= rxActive;                                      // [RULE17]
            rxState_ff <= RX_FRAME;                                      // [RULE14]
         end else if (rxActive && rxCloseFlag) begin
            rxState_ff    <= RX_HUNT;                                    // [RULE19]
            rxAccept_ff   <= rxLenOk && rxMatch;                         // [RULE13]
            rxAbort_ff    <= !(rxLenOk && rxMatch);
            rxCrcError_ff <= rxLenOk && !rxMatch;                        // [RULE21]
         end else if (rxActive && rxSymbolValid) begin
            if (symLegal(rxSymbol)) begin
               rxState_ff <= RX_FRAME;                                   // [RULE18]
            end else if (rxSymbol == `SYM_DARK && rxState_ff == RX_DARK1) begin
               rxState_ff <= RX_HUNT;                                    // [RULE15]
               rxAbort_ff <= 1'b1;
            end else if (!rxStopChip) begin
               rxState_ff <= RX_HUNT;                                    // [RULE16]
               rxAbort_ff <= 1'b1;
            end else if (rxSymbol == `SYM_DARK) begin
               rxState_ff <= RX_DARK1;
            end else begin
               rxState_ff <= RX_FRAME;
            end
         end
         rxInFrame_ff <= rxOpenFlag ||
                         (rxActive && !rxCloseFlag && !(rxSymbolValid &&
                          !symLegal(rxSymbol) && (!rxStopChip ||
                          (rxSymbol == `SYM_DARK && rxState_ff == RX_DARK1))));
      end
   end

   // ---------------------------------------------------------------
   // receive data path: the last 32 bits wait in a delay line so the
   // check register only sees payload, then the line holds the check field
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxDly_ff       <= 32'h00000000;
         rxSymCnt_ff    <= 5'h00;
         rxSymMod_ff    <= 2'h0;
         rxPair_ff      <= 2'h0;
         rxPairValid_ff <= 1'b0;
      end else begin
         rxPairValid_ff <= rxData;
         if (rxOpenFlag) begin
            rxSymCnt_ff <= 5'h00;
            rxSymMod_ff <= 2'h0;
         end else if (rxData) begin
            rxPair_ff   <= rxSymPair;                                    // [RULE18]
            rxDly_ff    <= {rxDly_ff[29:0], rxSymPair[0], rxSymPair[1]}; // [RULE5]
            rxSymMod_ff <= rxSymMod_ff + 2'h1;
            if (!rxFull) begin
               rxSymCnt_ff <= rxSymCnt_ff + 5'h01;
            end
         end
      end
   end

   fcs_crc32_shift #(.BITS(2)) rxFcs (
      .clk       (clk),
      .rstn      (rstn),
      .clr       (rxOpenFlag),
      .en        (rxData && rxFull),                                     // [RULE21]
      .shiftOnly (1'b0),
      .din       (rxDly_ff[31:30]),
      .crc_ff    (rxCrc)
   );

   // ---------------------------------------------------------------
   // apb registers, one wait-free access cycle
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdyq_ff   <= 1'b0;
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else begin
         prdyq_ff   <= psel & ~penable;
         pslverr_ff <= psel & ~penable & !(paddr == `REG_CTRL || paddr == `REG_STATUS ||
                       paddr == `REG_TXFCS || paddr == `REG_RXOK_CNT ||
                       paddr == `REG_RXBAD_CNT);
         if (apbRd) begin
            unique case (paddr)
               `REG_CTRL:      prdata_ff <= {30'h0, 1'b0, ctrl_ff[`CTRL_BADFCS_BIT]};
               `REG_STATUS:    prdata_ff <= {26'h0, rxState_ff, txState_ff, 2'h0} |
                                            {31'h0, rxInFrame_ff};
               `REG_TXFCS:     prdata_ff <= txCrc;
               `REG_RXOK_CNT:  prdata_ff <= {16'h0, okCnt_ff};
               `REG_RXBAD_CNT: prdata_ff <= {16'h0, badCnt_ff};
               default:        prdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= `CTRL_RESET;
      end else begin
         ctrl_ff[`CTRL_CLEAR_BIT] <= 1'b0;
         if (apbWr && paddr == `REG_CTRL) begin
            ctrl_ff[`CTRL_BADFCS_BIT] <= pwdata[`CTRL_BADFCS_BIT];
            ctrl_ff[`CTRL_CLEAR_BIT]  <= pwdata[`CTRL_CLEAR_BIT];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         okCnt_ff  <= `CNT_RESET;
         badCnt_ff <= `CNT_RESET;
      end else begin
         if (apbWr && paddr == `REG_RXOK_CNT) begin
            okCnt_ff <= `CNT_RESET;
         end else if (rxAccept_ff) begin
            okCnt_ff <= okCnt_ff + 16'h0001;
         end
         if (apbWr && paddr == `REG_RXBAD_CNT) begin
            badCnt_ff <= `CNT_RESET;
         end else if (rxAbort_ff) begin
            badCnt_ff <= badCnt_ff + 16'h0001;
         end
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = prdyq_ff;
   assign pslverr        = pslverr_ff;
   assign txBitOut       = txBitOut_ff;
   assign txBitOutValid  = txBitOutValid_ff;
   assign txCrcPhase     = txCrcPhase_ff;
   assign rxPair         = rxPair_ff;
   assign rxPairValid    = rxPairValid_ff;
   assign rxInFrame      = rxInFrame_ff;
   assign rxAccept       = rxAccept_ff;
   assign rxAbort        = rxAbort_ff;
   assign rxCrcError     = rxCrcError_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [5:0] phaseLen_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phaseLen_ff <= 6'h00;
      end else if (txCrcPhase_ff) begin
         phaseLen_ff <= phaseLen_ff + 6'h01;
      end else begin
         phaseLen_ff <= 6'h00;
      end
   end

   a_check_length: assert property (@(posedge clk) disable iff (!rstn) // [RULE22]
      $fell(txCrcPhase_ff) |-> $past(phaseLen_ff) == `FCS_CHECK_LAST)
      else $error("check phase not 32 clocks");

   a_tx_preset: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
      (txState_ff == TX_IDLE && txStart) |=> txCrc == `FCS_PRESET)
      else $error("check register not preset at packet start");

   a_payload_pass: assert property (@(posedge clk) disable iff (!rstn) // [RULE9]
      (txState_ff == TX_PAYLOAD && txBitValid) |=> txBitOut_ff == $past(txBitIn) && !txCrcPhase)
      else $error("payload bit altered on output");

   a_check_invert: assert property (@(posedge clk) disable iff (!rstn) // [RULE10]
      (txState_ff == TX_CHECK && !badFcs) |=> txBitOut_ff != $past(txCrc[31]))
      else $error("check bit not inverted");

   a_bad_fcs: assert property (@(posedge clk) disable iff (!rstn) // [RULE11]
      (txState_ff == TX_CHECK && badFcs) |=> txBitOut_ff == $past(txCrc[31]))
      else $error("corrupt check bit was inverted");

   a_preamble_groups: assert property (@(posedge clk) disable iff (!rstn) // [RULE20]
      (txState_ff == TX_PREAMBLE ##1 txState_ff == TX_PAYLOAD)
      |-> $past(groupCnt_ff) == `PREAMBLE_GROUPS)
      else $error("preamble group count wrong");

   a_dark_abort: assert property (@(posedge clk) disable iff (!rstn) // [RULE15]
      (rxState_ff == RX_DARK1 && rxSymbolValid && rxSymbol == `SYM_DARK
       && !rxOpenFlag && !rxCloseFlag) |=> rxAbort_ff && rxState_ff == RX_HUNT)
      else $error("double dark symbol did not abort");

   a_illegal_abort: assert property (@(posedge clk) disable iff (!rstn) // [RULE16]
      (rxActive && rxSymbolValid && !symLegal(rxSymbol) && !rxStopChip
       && !rxOpenFlag && !rxCloseFlag) |=> rxAbort_ff && !rxInFrame_ff)
      else $error("illegal symbol did not abort");

   a_accept_valid: assert property (@(posedge clk) disable iff (!rstn) // [RULE13]
      rxAccept_ff |-> $past(rxLenOk) && $past(rxMatch) && !rxAbort_ff)
      else $error("packet accepted without valid check field");

endmodule : ppm_packet_crc32_fcs

/* common/ppm_fcs_consts.svh */
// constants for the pulse-position packet frame check block
`ifndef PPM_FCS_CONSTS_SVH
`define PPM_FCS_CONSTS_SVH

// ---------------------------------------------------------------
// check calculation
// ---------------------------------------------------------------
`define FCS_WIDTH        32
`define FCS_PRESET       32'hFFFFFFFF
`define FCS_POLY         32'h04C11DB7
`define FCS_CHECK_CLKS   6'h20
`define FCS_CHECK_LAST   6'h1F
`define FCS_FILL_SYMS    5'h10

// ---------------------------------------------------------------
// framing
// ---------------------------------------------------------------
`define PREAMBLE_GROUPS  5'h10
`define SYM_DARK         4'h0

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define REG_TXFCS        12'h008
`define REG_RXOK_CNT     12'h00C
`define REG_RXBAD_CNT    12'h010
`define CTRL_BADFCS_BIT  0
`define CTRL_CLEAR_BIT   1
`define CTRL_RESET       32'h00000000
`define CNT_RESET        16'h0000

`endif

/* common/ppm_fcs_pkg.sv */
// types and helpers for the pulse-position packet frame check block
package ppm_fcs_pkg;

   // ---------------------------------------------------------------
   // state machines
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_IDLE     = 2'b00,
      TX_PREAMBLE = 2'b01,
      TX_PAYLOAD  = 2'b11,
      TX_CHECK    = 2'b10
   } txState_t;

   typedef enum logic [1:0] {
      RX_HUNT  = 2'b00,
      RX_FRAME = 2'b01,
      RX_DARK1 = 2'b11
   } rxState_t;

   // one lit chip among four; chip 1 is bit 3 and goes out first
   function automatic logic symLegal(input logic [3:0] sym);
      return (sym == 4'h8) || (sym == 4'h4) || (sym == 4'h2) || (sym == 4'h1);
   endfunction : symLegal

   // pair {b1,b0}: 00 chip1, 01 chip2, 10 chip3, 11 chip4
   function automatic logic [1:0] symPair(input logic [3:0] sym);
      logic [1:0] p;
      p = 2'h0;
      unique case (sym)
         4'h8:    p = 2'h0;
         4'h4:    p = 2'h1;
         4'h2:    p = 2'h2;
         4'h1:    p = 2'h3;
         default: p = 2'h0;
      endcase
      return p;
   endfunction : symPair

endpackage : ppm_fcs_pkg

/* logic/fcs_crc32_shift.sv */
// serial 32-bit check register, several bits per step
`timescale 1ns/1ns
`include "ppm_fcs_consts.svh"
module fcs_crc32_shift #(
   parameter int BITS = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             clr,
   input  wire logic             en,
   input  wire logic             shiftOnly,
   input  wire logic [BITS-1:0]  din,
   output logic      [31:0]      crc_ff
);
   logic [31:0] nxt_crc;

   // din[BITS-1] is taken first
   always_comb begin
      logic fb;
      fb = 1'b0;
      nxt_crc = crc_ff;
      for (int i = BITS - 1; i >= 0; i--) begin
         fb = (nxt_crc[31] ^ din[i]) & ~shiftOnly;                       // [RULE8] [RULE7]
         nxt_crc = {nxt_crc[30:0], 1'b0} ^ (`FCS_POLY & {32{fb}});        // [RULE3]
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         crc_ff <= `FCS_PRESET;                                          // [RULE12]
      end else if (clr) begin
         crc_ff <= `FCS_PRESET;                                          // [RULE6]
      end else if (en) begin
         crc_ff <= nxt_crc;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_clear_preset: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
      clr |=> crc_ff == `FCS_PRESET)
      else $error("check register not preset after clear");

   a_plain_shift: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
      (en && shiftOnly && !clr) |=> crc_ff == ($past(crc_ff) << BITS))
      else $error("check register not a plain shift in check phase");

endmodule : fcs_crc32_shift

/* dv/remote_endpoint.sv */
// remote link endpoint: preamble pacing and receive symbol source
`timescale 1ns/1ns
module remote_endpoint (
   input  wire logic       clk,
   input  wire logic       txSendPreamble,
   output logic            txGroupDone,
   output logic            rxOpenFlag,
   output logic            rxCloseFlag,
   output logic            rxSymbolValid,
   output logic [3:0]      rxSymbol,
   output logic            rxStopChip
);
   initial begin
      {txGroupDone, rxOpenFlag, rxCloseFlag, rxSymbolValid, rxStopChip} = 5'h00;
      rxSymbol = 4'h5;
   end
   always @(posedge clk) txGroupDone <= txSendPreamble & ~txGroupDone;
   task automatic sym(input logic [3:0] s, input logic stop);
      @(posedge clk);
      rxSymbolValid <= 1'h1;
      rxSymbol      <= s;
      rxStopChip    <= stop;
      @(posedge clk);
      rxSymbolValid <= 1'h0;
      rxSymbol      <= ~s;     // released line shows no stale symbol
      rxStopChip    <= 1'h0;
   endtask : sym
   task automatic flag(input logic open);
      @(posedge clk);
      rxOpenFlag  <= open;
      rxCloseFlag <= ~open;
      @(posedge clk);
      rxOpenFlag  <= 1'h0;
      rxCloseFlag <= 1'h0;
   endtask : flag
   // byte 0 first, low pair of each byte first; no gap between packets
   task automatic frame(input logic [47:0] d);
      flag(1'h1);
      for (int i = 0; i < 24; i++) sym(4'h8 >> d[2*i +: 2], 1'h0);
      flag(1'h0);
   endtask : frame
endmodule : remote_endpoint

/* dv/ppm_packet_crc32_fcs_bench.sv */
// self-checking bench for the packet frame check block
`timescale 1ns/1ns
`include "ppm_fcs_consts.svh"
module ppm_packet_crc32_fcs_bench;
   localparam logic [47:0] PKT = 48'h3954BE94A41B;
   logic        clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        txClear = 1'h0, txStart = 1'h0, txBitValid = 1'h0, txBitIn = 1'h0;
   logic        txLastBit = 1'h0, txBadFcs = 1'h0, pready, pslverr, txGroupDone;
   logic        txSendPreamble, txPayloadReady, txBitOut, txBitOutValid, txCrcPhase;
   logic        rxOpenFlag, rxCloseFlag, rxSymbolValid, rxStopChip, rxPairValid;
   logic        rxInFrame, rxAccept, rxAbort, rxCrcError;
   logic [3:0]  rxSymbol;
   logic [1:0]  rxPair;
   logic [47:0] cap, rxCap;
   int          fail_count = 0, checks_done = 0, nBits = 0, crcClks = 0;
   int          accN = 0, abN = 0, errN = 0;
   always #10 clk = ~clk;
   ppm_packet_crc32_fcs DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .txClear(txClear), .txStart(txStart), .txGroupDone(txGroupDone),
      .txBitValid(txBitValid), .txBitIn(txBitIn), .txLastBit(txLastBit),
      .txBadFcs(txBadFcs), .txSendPreamble(txSendPreamble), .txPayloadReady(txPayloadReady),
      .txBitOut(txBitOut), .txBitOutValid(txBitOutValid), .txCrcPhase(txCrcPhase),
      .rxOpenFlag(rxOpenFlag), .rxCloseFlag(rxCloseFlag), .rxSymbolValid(rxSymbolValid),
      .rxSymbol(rxSymbol), .rxStopChip(rxStopChip), .rxPair(rxPair),
      .rxPairValid(rxPairValid), .rxInFrame(rxInFrame), .rxAccept(rxAccept),
      .rxAbort(rxAbort), .rxCrcError(rxCrcError));
   remote_endpoint remote (.clk(clk), .txSendPreamble(txSendPreamble),
      .txGroupDone(txGroupDone), .rxOpenFlag(rxOpenFlag), .rxCloseFlag(rxCloseFlag),
      .rxSymbolValid(rxSymbolValid), .rxSymbol(rxSymbol), .rxStopChip(rxStopChip));
   always @(posedge clk) begin
      if (txBitOutValid === 1'h1) begin
         cap[nBits] <= txBitOut;
         nBits      <= nBits + 1;
      end
      if (txCrcPhase === 1'h1) crcClks <= crcClks + 1;
      if (rxAccept === 1'h1) accN <= accN + 1;
      if (rxAbort === 1'h1) abN <= abN + 1;
      if (rxCrcError === 1'h1) errN <= errN + 1;
      if (rxPairValid === 1'h1) rxCap <= {rxPair, rxCap[47:2]};
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic hang();
      fail_count++;
      print_verdict();
   endtask : hang
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      int i;
      @(posedge clk);
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'h1) break;
      end
      if (i == 20) hang();
      r       = prdata;
      err     = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic ee,
                        input string what);
      logic [31:0] r;
      logic        e;
      apb(1'h0, a, 32'h0, r, e);
      chk(what, {16'h0, exp}, {16'h0, r});
      chk("pslverr", {47'h0, ee}, {47'h0, e});
   endtask : rdChk
   task automatic txPacket(input logic bad, input logic [47:0] exp);
      int i;
      nBits   = 0;
      crcClks = 0;
      @(posedge clk);
      txBadFcs <= bad;
      txStart  <= 1'h1;
      @(posedge clk);
      txStart  <= 1'h0;
      for (i = 0; i < 300 && txPayloadReady !== 1'h1; i++) @(posedge clk);
      if (i == 300) hang();
      for (i = 0; i < 16; i++) begin
         txBitValid <= 1'h1;
         txBitIn    <= exp[i];
         txLastBit  <= (i == 15);
         @(posedge clk);
      end
      txBitValid <= 1'h0;
      txLastBit  <= 1'h0;
      repeat (40) @(posedge clk);
      chk("serial bits", exp, cap);
      chk("bit count", 48'h30, 48'(nBits));
      chk("check clocks", 48'h20, 48'(crcClks));
   endtask : txPacket
   task automatic txScenario();
      logic [31:0] r;
      logic        e;
      txPacket(1'h0, PKT);
      rdChk(`REG_TXFCS, 32'h0, 1'h0, "shifted out");
      apb(1'h1, `REG_CTRL, 32'h3, r, e);
      rdChk(`REG_CTRL, 32'h1, 1'h0, "ctrl readback");
      rdChk(`REG_TXFCS, 32'hFFFFFFFF, 1'h0, "ctrl clear");
      txPacket(1'h0, {~PKT[47:16], PKT[15:0]});
      apb(1'h1, `REG_CTRL, 32'h0, r, e);
      txPacket(1'h1, {~PKT[47:16], PKT[15:0]});
      @(posedge clk);
      txClear <= 1'h1;
      @(posedge clk);
      txClear <= 1'h0;
      rdChk(`REG_TXFCS, 32'hFFFFFFFF, 1'h0, "pin clear");
   endtask : txScenario
   task automatic rxScenario();
      remote.frame(PKT);
      remote.frame(PKT);
      repeat (4) @(posedge clk);
      chk("accepts", 48'h2, 48'(accN));
      chk("rx pairs", PKT, rxCap);
      remote.frame(PKT ^ 48'h010000000000);
      repeat (4) @(posedge clk);
      chk("check errors", 48'h1, 48'(errN));
      remote.flag(1'h1);
      remote.sym(4'h8, 1'h0);
      remote.sym(4'h0, 1'h1);
      remote.sym(4'h0, 1'h1);
      repeat (4) @(posedge clk);
      chk("dark abort", 48'h2, 48'(abN));
      remote.flag(1'h1);
      remote.sym(4'h6, 1'h0);
      repeat (4) @(posedge clk);
      chk("illegal abort", 48'h3, 48'(abN));
      rdChk(`REG_RXOK_CNT, 32'h2, 1'h0, "accept count");
      rdChk(`REG_RXBAD_CNT, 32'h3, 1'h0, "abort count");
   endtask : rxScenario
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      rdChk(`REG_CTRL, 32'h0, 1'h0, "ctrl reset");
      rdChk(`REG_TXFCS, 32'hFFFFFFFF, 1'h0, "reset preset");
      rdChk(12'hFFC, 32'h0, 1'h1, "unmapped");
      txScenario();
      rxScenario();
      print_verdict();
   end
endmodule : ppm_packet_crc32_fcs_bench
